// File: hw/pin_mux_pkg.sv
package pin_mux_pkg;
  // Byte addresses of the select registers on the AXI4-Lite slave
  localparam logic [31:0] sel_low_addr = 32'he002c000;
  localparam logic [31:0] sel_high_addr = 32'he002c004;
  localparam logic [31:0] sel_trace_addr = 32'he002c014;
  // Reset values
  localparam logic [31:0] sel_low_reset = 32'h00000000;
  localparam logic [31:0] sel_high_reset = 32'h00000000;
  localparam logic [31:0] sel_trace_reset = 32'h00000000;
  // Only bits 3:2 of the trace/debug register are implemented
  localparam logic [31:0] sel_trace_mask = 32'h0000000c;
  // Address bits 7:0, unused: the decoder compares all 32 address bits
  localparam int addr_lsb = 0;
  localparam int addr_msb = 7;
  // Selector codes
  localparam logic [1:0] code_gpio = 2'h0;
  localparam logic [1:0] code_f1 = 2'h1;
  localparam logic [1:0] code_f2 = 2'h2;
  localparam logic [1:0] code_f3 = 2'h3;
  // Bus responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  // Line count and selector width
  localparam int line_count = 16;
  localparam int field_width = 2;
endpackage : pin_mux_pkg

// File: hw/port_pin_function_select.sv
// Implementation choice: register access over AXI4-Lite.
module port_pin_function_select (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pads of port 0 lines 0..15; pad_oe_n low means the pad is driven
  input wire logic [15:0] pad_in,
  output logic [15:0] pad_out,
  output logic [15:0] pad_oe_n,
  // GPIO unit
  input wire logic [15:0] gpio_out,
  input wire logic [15:0] gpio_direction_register,
  output logic [15:0] gpio_in,
  // Peripheral outputs and their drive enables (active high)
  input wire logic uart0_txd,
  input wire logic pulse_output_1,
  input wire logic pulse_output_2,
  input wire logic pulse_output_3,
  input wire logic pulse_output_4,
  input wire logic pulse_output_6,
  input wire logic i2c_scl_low,
  input wire logic i2c_sda_low,
  input wire logic spi0_sck_out,
  input wire logic spi0_sck_oe,
  input wire logic spi0_miso_out,
  input wire logic spi0_miso_oe,
  input wire logic spi0_mosi_out,
  input wire logic spi0_mosi_oe,
  input wire logic timer0_match_0,
  input wire logic timer0_match_1,
  input wire logic timer1_match_0,
  input wire logic timer1_match_1,
  input wire logic uart1_txd,
  input wire logic uart1_rts,
  input wire logic uart1_dtr,
  // Peripheral inputs
  output logic uart0_rxd,
  output logic uart1_rxd,
  output logic uart1_cts,
  output logic uart1_dsr,
  output logic uart1_dcd,
  output logic uart1_ri,
  output logic i2c_scl_in,
  output logic i2c_sda_in,
  output logic spi0_sck_in,
  output logic spi0_miso_in,
  output logic spi0_mosi_in,
  output logic spi0_ssel_in,
  output logic [2:0] timer0_capture,
  output logic [1:0] timer1_capture,
  output logic [3:0] ext_irq_line,
  // Trace and debug port enables from the third register
  output logic debug_port_enable,
  output logic trace_port_enable
);

  typedef struct packed {
    logic [31:0] sel_low;
    logic [31:0] sel_high;
    logic [31:0] sel_trace;
    logic aw_held;
    logic [31:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_ready;
    logic w_ready;
    logic ar_ready;
    logic [15:0] pad_out;
    logic [15:0] pad_oe_n;
    logic [15:0] gpio_in;
    logic [5:0] uart_in;
    logic [1:0] i2c_in;
    logic [3:0] spi_in;
    logic [2:0] cap0;
    logic [1:0] cap1;
    logic [3:0] irq;
  } state_type;

  state_type cur;
  state_type next_cur;

  // Selector of line n
  function automatic logic [1:0] sel_of(input logic [31:0] reg_val, input int n);
    sel_of = reg_val[n*pin_mux_pkg::field_width +: pin_mux_pkg::field_width];
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    merge = res;
  endfunction

  // Bus slave and the pin crossbar, all computed into next_cur
  always_comb begin
    logic [1:0] s;
    logic [15:0] fn_out;
    logic [15:0] fn_drv;
    logic [15:0] fn_sel;
    logic [3:0] irq_v;
    next_cur = cur;
    s = 2'h0;
    fn_out = 16'h0000;
    fn_drv = 16'h0000;
    fn_sel = 16'h0000;
    irq_v = 4'h0;

    // Write address and data are taken in either order, then answered together
    if (s_axi_awvalid && cur.aw_ready) begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && cur.w_ready) begin
      next_cur.w_held = 1'b1;
      next_cur.w_data = s_axi_wdata;
      next_cur.w_strb = s_axi_wstrb;
    end
    if (cur.aw_held && cur.w_held) begin
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = pin_mux_pkg::resp_okay;
      unique case (cur.aw_addr)
        pin_mux_pkg::sel_low_addr: begin
          next_cur.sel_low = merge(cur.sel_low, cur.w_data, cur.w_strb);
        end
        pin_mux_pkg::sel_high_addr: begin
          next_cur.sel_high = merge(cur.sel_high, cur.w_data, cur.w_strb);
        end
        pin_mux_pkg::sel_trace_addr: begin
          next_cur.sel_trace = merge(cur.sel_trace, cur.w_data, cur.w_strb)
                               & pin_mux_pkg::sel_trace_mask;
        end
        default: begin
          next_cur.bresp = pin_mux_pkg::resp_slverr;
        end
      endcase
    end
    if (cur.bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken
    if (s_axi_arvalid && cur.ar_ready) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = pin_mux_pkg::resp_okay;
      unique case (s_axi_araddr)
        pin_mux_pkg::sel_low_addr: next_cur.rdata = cur.sel_low;
        pin_mux_pkg::sel_high_addr: next_cur.rdata = cur.sel_high;
        pin_mux_pkg::sel_trace_addr: next_cur.rdata = cur.sel_trace;
        default: begin
          next_cur.rdata = 32'h00000000;
          next_cur.rresp = pin_mux_pkg::resp_slverr;
        end
      endcase
    end else if (cur.rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'b0;
    end

    // Output functions per line; reserved codes fall back to an undriven input
    for (int n = 0; n < pin_mux_pkg::line_count; n++) begin
      s = sel_of(cur.sel_low, n);
      fn_sel[n] = (s != pin_mux_pkg::code_gpio);
      unique case (n)
        0: if (s == pin_mux_pkg::code_f1) begin fn_out[n] = uart0_txd; fn_drv[n] = 1'b1; end
           else if (s == pin_mux_pkg::code_f2) begin
             fn_out[n] = pulse_output_1; fn_drv[n] = 1'b1;
           end
        1: if (s == pin_mux_pkg::code_f2) begin fn_out[n] = pulse_output_3; fn_drv[n] = 1'b1; end
        2: if (s == pin_mux_pkg::code_f1) begin fn_drv[n] = i2c_scl_low; end
        3: if (s == pin_mux_pkg::code_f1) begin fn_drv[n] = i2c_sda_low; end
           else if (s == pin_mux_pkg::code_f2) begin
             fn_out[n] = timer0_match_0; fn_drv[n] = 1'b1;
           end
        4: if (s == pin_mux_pkg::code_f1) begin
             fn_out[n] = spi0_sck_out; fn_drv[n] = spi0_sck_oe;
           end
        5: if (s == pin_mux_pkg::code_f1) begin
             fn_out[n] = spi0_miso_out; fn_drv[n] = spi0_miso_oe;
           end else if (s == pin_mux_pkg::code_f2) begin
             fn_out[n] = timer0_match_1; fn_drv[n] = 1'b1;
           end
        6: if (s == pin_mux_pkg::code_f1) begin
             fn_out[n] = spi0_mosi_out; fn_drv[n] = spi0_mosi_oe;
           end
        7: if (s == pin_mux_pkg::code_f2) begin fn_out[n] = pulse_output_2; fn_drv[n] = 1'b1; end
        8: if (s == pin_mux_pkg::code_f1) begin fn_out[n] = uart1_txd; fn_drv[n] = 1'b1; end
           else if (s == pin_mux_pkg::code_f2) begin
             fn_out[n] = pulse_output_4; fn_drv[n] = 1'b1;
           end
        9: if (s == pin_mux_pkg::code_f2) begin fn_out[n] = pulse_output_6; fn_drv[n] = 1'b1; end
        10: if (s == pin_mux_pkg::code_f1) begin fn_out[n] = uart1_rts; fn_drv[n] = 1'b1; end
        12: if (s == pin_mux_pkg::code_f2) begin
              fn_out[n] = timer1_match_0; fn_drv[n] = 1'b1;
            end
        13: if (s == pin_mux_pkg::code_f1) begin fn_out[n] = uart1_dtr; fn_drv[n] = 1'b1; end
            else if (s == pin_mux_pkg::code_f2) begin
              fn_out[n] = timer1_match_1; fn_drv[n] = 1'b1;
            end
        default: begin
        end
      endcase
      // GPIO direction only counts while GPIO is selected
      if (fn_sel[n]) begin
        next_cur.pad_out[n] = fn_out[n];
        next_cur.pad_oe_n[n] = !fn_drv[n];
      end else begin
        next_cur.pad_out[n] = gpio_out[n];
        next_cur.pad_oe_n[n] = !gpio_direction_register[n];
      end
    end

    // Input functions: pad when routed, idle level otherwise; gpio_in always follows the pad
    next_cur.gpio_in = pad_in;
    next_cur.uart_in[0] = (sel_of(cur.sel_low, 1) == pin_mux_pkg::code_f1) ? pad_in[1] : 1'b1;
    next_cur.uart_in[1] = (sel_of(cur.sel_low, 9) == pin_mux_pkg::code_f1) ? pad_in[9] : 1'b1;
    next_cur.uart_in[2] = (sel_of(cur.sel_low, 11) == pin_mux_pkg::code_f1) ? pad_in[11] : 1'b1;
    next_cur.uart_in[3] = (sel_of(cur.sel_low, 12) == pin_mux_pkg::code_f1) ? pad_in[12] : 1'b1;
    next_cur.uart_in[4] = (sel_of(cur.sel_low, 14) == pin_mux_pkg::code_f1) ? pad_in[14] : 1'b1;
    next_cur.uart_in[5] = (sel_of(cur.sel_low, 15) == pin_mux_pkg::code_f1) ? pad_in[15] : 1'b1;
    // I2C lines idle high
    next_cur.i2c_in[0] = (sel_of(cur.sel_low, 2) == pin_mux_pkg::code_f1) ? pad_in[2] : 1'b1;
    next_cur.i2c_in[1] = (sel_of(cur.sel_low, 3) == pin_mux_pkg::code_f1) ? pad_in[3] : 1'b1;
    next_cur.spi_in[0] = (sel_of(cur.sel_low, 4) == pin_mux_pkg::code_f1) ? pad_in[4] : 1'b0;
    next_cur.spi_in[1] = (sel_of(cur.sel_low, 5) == pin_mux_pkg::code_f1) ? pad_in[5] : 1'b0;
    next_cur.spi_in[2] = (sel_of(cur.sel_low, 6) == pin_mux_pkg::code_f1) ? pad_in[6] : 1'b0;
    // Slave select idles high so an unrouted SPI is never selected
    next_cur.spi_in[3] = (sel_of(cur.sel_low, 7) == pin_mux_pkg::code_f1) ? pad_in[7] : 1'b1;
    next_cur.cap0[0] = (sel_of(cur.sel_low, 2) == pin_mux_pkg::code_f2) && pad_in[2];
    next_cur.cap0[1] = (sel_of(cur.sel_low, 4) == pin_mux_pkg::code_f2) && pad_in[4];
    next_cur.cap0[2] = (sel_of(cur.sel_low, 6) == pin_mux_pkg::code_f2) && pad_in[6];
    next_cur.cap1[0] = (sel_of(cur.sel_low, 10) == pin_mux_pkg::code_f2) && pad_in[10];
    next_cur.cap1[1] = (sel_of(cur.sel_low, 11) == pin_mux_pkg::code_f2) && pad_in[11];
    // Irq inputs idle high; two pins on one irq combine as a wired AND of their levels
    irq_v = 4'hf;
    if (sel_of(cur.sel_low, 1) == pin_mux_pkg::code_f3) irq_v[0] = pad_in[1];
    if (sel_of(cur.sel_low, 3) == pin_mux_pkg::code_f3) irq_v[1] = pad_in[3];
    if (sel_of(cur.sel_low, 14) == pin_mux_pkg::code_f2) irq_v[1] = irq_v[1] & pad_in[14];
    if (sel_of(cur.sel_low, 7) == pin_mux_pkg::code_f3) irq_v[2] = pad_in[7];
    if (sel_of(cur.sel_low, 15) == pin_mux_pkg::code_f2) irq_v[2] = irq_v[2] & pad_in[15];
    if (sel_of(cur.sel_low, 9) == pin_mux_pkg::code_f3) irq_v[3] = pad_in[9];
    next_cur.irq = irq_v;

    // Readies follow the next holding state; costs one idle cycle after reset
    next_cur.aw_ready = !next_cur.aw_held && !next_cur.bvalid;
    next_cur.w_ready = !next_cur.w_held && !next_cur.bvalid;
    next_cur.ar_ready = !next_cur.rvalid;

    if (!aresetn) begin
      next_cur = '0;
      next_cur.sel_low = pin_mux_pkg::sel_low_reset;
      next_cur.sel_high = pin_mux_pkg::sel_high_reset;
      next_cur.sel_trace = pin_mux_pkg::sel_trace_reset;
      next_cur.pad_oe_n = 16'hffff;
      next_cur.uart_in = 6'h3f;
      next_cur.i2c_in = 2'h3;
      next_cur.spi_in = 4'h8;
      next_cur.irq = 4'hf;
    end
  end

  // Single state register; reset is folded into next_cur
  always_ff @(posedge aclk) begin
    cur <= next_cur;
  end

  // Ready flags are registered so the handshake never loops combinationally
  assign s_axi_awready = cur.aw_ready;
  assign s_axi_wready = cur.w_ready;
  assign s_axi_arready = cur.ar_ready;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;
  assign pad_out = cur.pad_out;
  assign pad_oe_n = cur.pad_oe_n;
  assign gpio_in = cur.gpio_in;
  assign {uart1_ri, uart1_dcd, uart1_dsr, uart1_cts, uart1_rxd, uart0_rxd} = cur.uart_in;
  assign {i2c_sda_in, i2c_scl_in} = cur.i2c_in;
  assign {spi0_ssel_in, spi0_mosi_in, spi0_miso_in, spi0_sck_in} = cur.spi_in;
  assign timer0_capture = cur.cap0;
  assign timer1_capture = cur.cap1;
  assign ext_irq_line = cur.irq;
  assign debug_port_enable = cur.sel_trace[2];
  assign trace_port_enable = cur.sel_trace[3];

  // Checks
  reset_low_a: assert property (@(posedge aclk) $rose(aresetn) |-> cur.sel_low == 32'h0)
    else $error("low select not zero after reset");
  gpio_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(cur.sel_low[1:0]) == 2'h0 && $past(aresetn)) |->
    pad_oe_n[0] == !$past(gpio_direction_register[0]))
    else $error("gpio direction not applied on line 0");
  write_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cur.aw_held && cur.w_held && cur.aw_addr == pin_mux_pkg::sel_low_addr && cur.w_strb == 4'hf)
    |=> cur.sel_low == $past(cur.w_data))
    else $error("low select write lost");
  scl_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(cur.sel_low[5:4]) == 2'h1 && $past(aresetn)) |-> i2c_scl_in == $past(pad_in[2]))
    else $error("scl input not routed");
  cap01_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(cur.sel_low[9:8]) != 2'h2 && $past(aresetn)) |-> !timer0_capture[1])
    else $error("capture 0.1 active while unrouted");
  mosi_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(cur.sel_low[13:12]) == 2'h1 && $past(aresetn)) |-> pad_oe_n[6] == !$past(spi0_mosi_oe))
    else $error("mosi drive wrong");
  rts_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(cur.sel_low[21:20]) == 2'h1 && $past(aresetn)) |-> pad_out[10] == $past(uart1_rts))
    else $error("rts not routed");
  cts_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(cur.sel_low[23:22]) != 2'h1 && $past(aresetn)) |-> uart1_cts)
    else $error("cts not idle while unrouted");
  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped");
  write_cov: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  read_cov: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  func_cov: cover property (@(posedge aclk) cur.sel_low[1:0] == 2'h1);

endmodule // port_pin_function_select

// File: sim/pin_partner.sv
// Pads, GPIO unit and on-chip peripherals seen from outside the pin mux
module pin_partner (
  input wire logic aclk,
  input wire logic active,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe_n,
  output logic [15:0] pad_in,
  output logic [15:0] gpio_out,
  output logic [15:0] gpio_direction_register,
  output logic [20:0] po
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 60;
  logic [15:0] ext;

  initial begin
    {pad_in, gpio_out, gpio_direction_register} = 48'h0;
    po = 21'h0;
  end

  // A released pad shows a fresh level each cycle, so a stale value never passes
  always @(posedge aclk) begin
    ext = 16'($random(seed));
    pad_in <= (pad_out & ~pad_oe_n) | (ext & pad_oe_n);
    gpio_out <= 16'($random(seed));
    gpio_direction_register <= 16'($random(seed));
    po <= active ? 21'($random(seed)) : 21'h0;
  end
endmodule // pin_partner

// File: sim/tb_top.sv
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[FAIL] %0t got %h expected %h", $time, (g), (e)); \
  end \
end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] oe_n;
    logic [15:0] out;
    logic [20:0] ins;
    logic [15:0] gin;
    logic [1:0] en;
  } pin_exp_type;
  // Output source per line and code 1..3; 1f marks an input or reserved code
  localparam logic [4:0] tbl [48] = '{
    5'h00, 5'h01, 5'h1f, 5'h1f, 5'h03, 5'h1f, 5'h06, 5'h1f, 5'h1f, 5'h07, 5'h0e, 5'h1f,
    5'h08, 5'h1f, 5'h1f, 5'h0a, 5'h0f, 5'h1f, 5'h0c, 5'h1f, 5'h1f, 5'h1f, 5'h02, 5'h1f,
    5'h12, 5'h04, 5'h1f, 5'h1f, 5'h05, 5'h1f, 5'h13, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f,
    5'h1f, 5'h10, 5'h1f, 5'h14, 5'h11, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f};
  localparam logic [31:0] adr [3] = '{pin_mux_pkg::sel_low_addr,
    pin_mux_pkg::sel_high_addr, pin_mux_pkg::sel_trace_addr};
  localparam logic [31:0] rst [3] = '{pin_mux_pkg::sel_low_reset,
    pin_mux_pkg::sel_high_reset, pin_mux_pkg::sel_trace_reset};
  localparam logic [31:0] msk [3] = '{32'hffffffff, 32'hffffffff, pin_mux_pkg::sel_trace_mask};
  localparam logic [31:0] pat [4] = '{32'h00000000, 32'h55555555, 32'haaaaaaaa, 32'h000cc0cc};
  localparam logic [1:0] ok = pin_mux_pkg::resp_okay;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d, sh_low, sh_tr;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, br;
  logic [15:0] pad_in, pad_out, pad_oe_n, gpio_out, gpio_direction_register, gpio_in;
  logic [20:0] po;
  logic uart0_rxd, uart1_rxd, uart1_cts, uart1_dsr, uart1_dcd, uart1_ri, i2c_scl_in, i2c_sda_in;
  logic spi0_sck_in, spi0_miso_in, spi0_mosi_in, spi0_ssel_in, debug_port_enable, trace_port_enable;
  logic [2:0] timer0_capture;
  logic [1:0] timer1_capture;
  logic [3:0] ext_irq_line;
  logic chk = 1'b0;
  logic active = 1'b0;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 60;
  int i;
  logic [1:0] bq [$];
  logic [33:0] rq [$];
  logic [33:0] re;
  pin_exp_type pq [$];
  pin_exp_type pe;

  port_pin_function_select uut (.*, .uart0_txd(po[0]), .pulse_output_1(po[1]),
    .pulse_output_2(po[2]), .pulse_output_3(po[3]), .pulse_output_4(po[4]),
    .pulse_output_6(po[5]), .i2c_scl_low(po[6]), .i2c_sda_low(po[7]), .spi0_sck_out(po[8]),
    .spi0_sck_oe(po[9]), .spi0_miso_out(po[10]), .spi0_miso_oe(po[11]),
    .spi0_mosi_out(po[12]), .spi0_mosi_oe(po[13]), .timer0_match_0(po[14]),
    .timer0_match_1(po[15]), .timer1_match_0(po[16]), .timer1_match_1(po[17]),
    .uart1_txd(po[18]), .uart1_rts(po[19]), .uart1_dtr(po[20]));
  pin_partner partner (.aclk(aclk), .active(active), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_in(pad_in), .gpio_out(gpio_out), .gpio_direction_register(gpio_direction_register),
    .po(po));

  always #10 aclk = ~aclk;

  // Code 3 is kept only on lines that list it, as software must
  function automatic logic [31:0] legal(logic [31:0] r);
    return r ^ (r & (r >> 1) & 32'h55555555 & ~32'h00044044);
  endfunction

  // Level a routed input function sees, else its idle level
  function automatic logic rt(int n, int c, int idle);
    return (int'(sh_low[2*n +: 2]) == c) ? pad_in[n] : idle[0];
  endfunction

  // Pin state expected one edge after the inputs now sampled
  function automatic pin_exp_type pins();
    pin_exp_type x;
    logic [1:0] c;
    logic [4:0] k;
    int n;
    x = '0;
    x.oe_n = 16'hffff;
    for (n = 0; n < 16; n++) begin
      c = sh_low[2*n +: 2];
      k = (c == 2'h0) ? 5'h1f : tbl[n*3+c-1];
      if (c == 2'h0) {x.oe_n[n], x.out[n]} = {~gpio_direction_register[n], gpio_out[n]};
      else if (k == 5'h06 || k == 5'h07) x.oe_n[n] = ~po[k];
      else if (k == 5'h08 || k == 5'h0a || k == 5'h0c) {x.oe_n[n], x.out[n]} = {~po[k+1], po[k]};
      else if (k != 5'h1f) {x.oe_n[n], x.out[n]} = {1'b0, po[k]};
    end
    x.ins = {rt(1,1,1), rt(9,1,1), rt(11,1,1), rt(12,1,1), rt(14,1,1), rt(15,1,1), rt(2,1,1),
      rt(3,1,1), rt(4,1,0), rt(5,1,0), rt(6,1,0), rt(7,1,1), rt(6,2,0), rt(4,2,0), rt(2,2,0),
      rt(11,2,0), rt(10,2,0), rt(9,3,1), rt(7,3,1) & rt(15,2,1), rt(3,3,1) & rt(14,2,1),
      rt(1,3,1)};
    x.gin = pad_in;
    x.en = sh_tr[3:2];
    return x;
  endfunction

  task automatic wr(logic [31:0] a, logic [31:0] v, logic [3:0] s, logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(logic [31:0] a, logic [31:0] v, logic [1:0] r);
    rq.push_back({r, v});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Bus answers are matched to the oldest note of their kind
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      br = bq.pop_front();
      `CHK(s_axi_bresp, br)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      re = rq.pop_front();
      `CHK(s_axi_rresp, re[33:32])
      `CHK(s_axi_rdata, re[31:0])
    end
    if (chk) pq.push_back(pins());
  end

  // Pin outputs are compared mid-cycle, once the launching edge has settled
  always @(negedge aclk) begin
    if (pq.size() > 0) begin
      pe = pq.pop_front();
      `CHK(pad_oe_n, pe.oe_n)
      `CHK(pad_out & ~pe.oe_n, pe.out & ~pe.oe_n)
      `CHK({uart0_rxd, uart1_rxd, uart1_cts, uart1_dsr, uart1_dcd, uart1_ri, i2c_scl_in,
        i2c_sda_in, spi0_sck_in, spi0_miso_in, spi0_mosi_in, spi0_ssel_in, timer0_capture,
        timer1_capture, ext_irq_line}, pe.ins)
      `CHK(gpio_in, pe.gin)
      `CHK({trace_port_enable, debug_port_enable}, pe.en)
    end
  end

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} <= 100'h0;
    {sh_low, sh_tr} = 64'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset value, then write and read back each register, back to back
    for (i = 0; i < 3; i++) begin
      d = legal($random(seed));
      rd(adr[i], rst[i], ok);
      wr(adr[i], d, 4'hf, ok);
      rd(adr[i], d & msk[i], ok);
      if (i == 0) sh_low = d;
    end
    // One byte lane only; the other lanes must keep their selectors
    d = legal($random(seed));
    wr(adr[0], d, 4'h2, ok);
    rd(adr[0], (sh_low & 32'hffff00ff) | (d & 32'h0000ff00), ok);
    wr(pin_mux_pkg::sel_low_addr + 32'h8, d, 4'hf, pin_mux_pkg::resp_slverr);
    rd(pin_mux_pkg::sel_low_addr + 32'h8, 32'h0, pin_mux_pkg::resp_slverr);
    // Every listed code on every line, then random legal mixes
    for (i = 0; i < 12; i++) begin
      d = (i < 4) ? pat[i] : legal($random(seed));
      wr(adr[0], d, 4'hf, ok);
      sh_low = d;
      wr(adr[2], {28'h0, i[1:0], 2'h0}, 4'hf, ok);
      sh_tr = {28'h0, i[1:0], 2'h0};
      active <= 1'b1;
      chk <= 1'b1;
      repeat (20) @(posedge aclk);
      chk <= 1'b0;
    end
    repeat (2) @(posedge aclk);
    print_verdict();
  end
endmodule // tb_top
